//--- rtl/tcm_port_consts.svh
// Overview of operation
// - Select asserted in request cycle, access follows.
// - Quiet flag shows no internal access this cycle.
// - Attributes valid whenever select is asserted.
// - Follow-on flag marks sequential; high while waited, low under DMA takeover.
// - Word index is eighteen bits of words.
// - Byte lanes from address, size, endianness; reads zero.
// - Write word held through penultimate access cycle.
// - DMA takeover steers select and index outputs.
// - Takeover select follows DMA select input.
// - Takeover index equals DMA index unchanged.
// - Data sequential only back to back.
// - Instruction port never issues sequential writes.
// - Waited cycles: follow-on high unless DMA takes over, write word held.
// - Final data cycle overlaps next request cycle.
// - DMA stalls request; reissue as non-sequential.
// - Instruction port mirrors data port except in its sequencing.
// - Stall input ignored when no access active.
`ifndef TCM_PORT_CONSTS_SVH
`define TCM_PORT_CONSTS_SVH

// Width of the word index towards the memory.
`define WORD_INDEX_W 18
// Width of a memory word.
`define DATA_W 32
// Width of the byte address carried by a request.
`define BYTE_ADDR_W 20
// Number of byte lanes in a word.
`define LANE_W 4
// Default depth of the request FIFO.
`define REQ_FIFO_DEPTH 16
// Lane pattern for reads and for no lanes at all.
`define LANES_NONE 4'h0
// Lane pattern for a whole word.
`define LANES_ALL 4'hF
// Lane pattern for the lower halfword.
`define LANES_LOW_HALF 4'h3
// Lane pattern for the upper halfword.
`define LANES_HIGH_HALF 4'hC
// Lane pattern for the lowest byte, shifted by the byte offset.
`define LANE_ONE 4'h1
// Highest byte offset within a word.
`define LAST_BYTE 2'h3
// Step between consecutive word indexes.
`define INDEX_STEP 18'h00001

`endif

//--- rtl/tcm_port_pkg.sv
package tcm_port_pkg;

  // Transfer size of a request.
  typedef enum logic [1:0] {
    SIZE_BYTE,
    SIZE_HALF,
    SIZE_WORD
  } size_t;

  // One request from the processor side.
  typedef struct packed {
    logic write;
    logic [19:0] byteAddr;
    size_t size;
    logic [31:0] wdata;
  } req_t;

  // All state of one port side.
  typedef struct packed {
    logic busy;
    logic stallPrev;
    logic wasWrite;
    logic forceNseq;
    logic lastIssue;
    logic prevValid;
    logic [17:0] prevIndex;
    logic [31:0] wdata;
    logic respValid;
    logic [31:0] respData;
  } side_state_t;

  // State of the request FIFO pointers.
  typedef struct packed {
    logic [4:0] count;
    logic [3:0] wrPtr;
    logic [3:0] rdPtr;
  } fifo_state_t;

endpackage

//--- rtl/tightly_coupled_sram_port.sv
`timescale 1ns/10ps
`include "tcm_port_consts.svh"

// Request FIFO that decouples the processor side from memory timing.
module tcm_req_fifo
  import tcm_port_pkg::*;
#(
  parameter int WIDTH = $bits(req_t),
  parameter int DEPTH = `REQ_FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Filling side.
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Draining side.
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  // Storage for queued requests.
  logic [WIDTH-1:0] mem [DEPTH];
  // Pointer and fill state.
  logic [AW:0] countReg;
  logic [AW-1:0] wrPtrReg;
  logic [AW-1:0] rdPtrReg;
  logic push;
  logic pop;

  // Full and empty come straight from the fill count.
  always_comb begin
    inReady = (countReg != DEPTH[AW:0]);
    outValid = (countReg != '0);
    outData = mem[rdPtrReg];
    push = inValid && inReady;
    pop = outValid && outReady;
  end

  // Pointers advance on each accepted push and pop.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      countReg <= '0;
      wrPtrReg <= '0;
      rdPtrReg <= '0;
    end else begin
      if (push) begin
        wrPtrReg <= (wrPtrReg == AW'(DEPTH - 1)) ? '0 : wrPtrReg + 1'b1;
      end
      if (pop) begin
        rdPtrReg <= (rdPtrReg == AW'(DEPTH - 1)) ? '0 : rdPtrReg + 1'b1;
      end
      if (push && !pop) begin
        countReg <= countReg + 1'b1;
      end else if (pop && !push) begin
        countReg <= countReg - 1'b1;
      end
    end
  end

  // The array itself needs no reset.
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wrPtrReg] <= inData;
    end
  end
endmodule

// One side of the port: request issue, wait handling and DMA steering.
module tcm_port_side
  import tcm_port_pkg::*;
#(
  parameter bit INSTR_SIDE = 1'b0,
  parameter int FIFO_DEPTH = `REQ_FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Processor request stream.
  input wire logic reqValid,
  output logic reqReady,
  input wire req_t reqData,
  input wire logic bigEndian,
  // Read answers.
  output logic respValid,
  output logic [`DATA_W-1:0] respData,
  // Memory side.
  output logic memSelect,
  input wire logic memStall,
  output logic portQuiet,
  output logic followOn,
  output logic [`WORD_INDEX_W-1:0] wordIndex,
  output logic [`LANE_W-1:0] byteLanes,
  output logic writeNotRead,
  input wire logic [`DATA_W-1:0] readWord,
  output logic [`DATA_W-1:0] writeWord,
  // DMA insertion.
  input wire logic dmaTakeover,
  input wire logic dmaSelect,
  input wire logic [`WORD_INDEX_W-1:0] dmaIndex
);
  // Checks sample on this clock, off in reset.
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  // Lanes to update for a write from offset, size and endianness.
  function automatic logic [`LANE_W-1:0] laneMask(input logic [1:0] offs, input size_t sz,
                                                  input logic big);
    logic [1:0] pos;
    pos = big ? (`LAST_BYTE - offs) : offs;
    case (sz)
      SIZE_BYTE: laneMask = `LANE_ONE << pos;
      SIZE_HALF: laneMask = (pos[1]) ? `LANES_HIGH_HALF : `LANES_LOW_HALF;
      default: laneMask = `LANES_ALL;
    endcase
  endfunction

  side_state_t stateReg;
  side_state_t stateNext;
  // Head of the queue.
  logic headValid;
  logic [$bits(req_t)-1:0] headBits;
  req_t head;
  // Decoded cycle kinds.
  logic completeNow;
  logic waitedCycle;
  logic wantIssue;
  logic issue;
  logic seqInt;
  logic [`WORD_INDEX_W-1:0] headIndex;

  tcm_req_fifo #(
    .WIDTH($bits(req_t)),
    .DEPTH(FIFO_DEPTH)
  ) reqQueue (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .inValid(reqValid),
    .inReady(reqReady),
    .inData(reqData),
    .outValid(headValid),
    .outReady(issue),
    .outData(headBits)
  );

  // Output decode and next state.
  always_comb begin
    head = req_t'(headBits);
    headIndex = head.byteAddr[`BYTE_ADDR_W-1:2];
    // A data phase ends when the stall seen one cycle earlier was low.
    completeNow = stateReg.busy && !stateReg.stallPrev;
    waitedCycle = stateReg.busy && stateReg.stallPrev;
    // Issue may overlap the final data cycle of the previous access.
    wantIssue = headValid && !sys_rst && (!stateReg.busy || completeNow);
    issue = wantIssue && !dmaTakeover;
    seqInt = stateReg.prevValid && !stateReg.forceNseq
             && (headIndex == stateReg.prevIndex + `INDEX_STEP)
             && (INSTR_SIDE || stateReg.lastIssue)
             && !(INSTR_SIDE && head.write);
    portQuiet = !wantIssue;
    // Select and index come from DMA while it has the port.
    memSelect = dmaTakeover ? dmaSelect : issue;
    wordIndex = dmaTakeover ? dmaIndex : headIndex;
    writeNotRead = head.write;
    byteLanes = head.write ? laneMask(head.byteAddr[1:0], head.size, bigEndian)
                           : `LANES_NONE;
    // Waited cycles force the flag high; DMA cycles force it low.
    if (dmaTakeover) begin
      followOn = 1'b0;
    end else if (waitedCycle) begin
      followOn = 1'b1;
    end else begin
      followOn = issue && seqInt;
    end
    // Write word is presented at issue and held afterwards.
    writeWord = issue ? head.wdata : stateReg.wdata;
    respValid = stateReg.respValid;
    respData = stateReg.respData;

    stateNext = stateReg;
    stateNext.respValid = 1'b0;
    // Read data arrives in the final data cycle.
    if (completeNow && !stateReg.wasWrite) begin
      stateNext.respValid = 1'b1;
      stateNext.respData = readWord;
    end
    if (completeNow) begin
      stateNext.busy = 1'b0;
    end
    // Stall only counts in a request or waited cycle.
    stateNext.stallPrev = (issue || waitedCycle) ? memStall : 1'b0;
    stateNext.lastIssue = issue;
    if (issue) begin
      stateNext.busy = 1'b1;
      stateNext.wasWrite = head.write;
      stateNext.wdata = head.wdata;
      stateNext.prevValid = 1'b1;
      stateNext.prevIndex = headIndex;
      stateNext.forceNseq = 1'b0;
    end
    // A DMA access, or a takeover that holds back a request, breaks the sequential chain.
    if (dmaTakeover && (dmaSelect || wantIssue)) begin
      stateNext.forceNseq = 1'b1;
    end
  end

  // Register the whole state.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      stateReg <= '0;
    end else begin
      stateReg <= stateNext;
    end
  end

  // Checks on the driven memory side.
  property p_selectQuiet;
    !dmaTakeover |-> (memSelect == !portQuiet);
  endproperty
  a_selectQuiet: assert property (p_selectQuiet) else $error("select and quiet disagree");

  property p_waitSeqHigh;
    (memSelect && memStall && !dmaTakeover) ##1 !dmaTakeover |-> followOn && !memSelect;
  endproperty
  a_waitSeqHigh: assert property (p_waitSeqHigh) else $error("waited cycle flag not high");

  property p_wdataHold;
    (memSelect && !dmaTakeover && writeNotRead && memStall) |=> $stable(writeWord);
  endproperty
  a_wdataHold: assert property (p_wdataHold) else $error("write word changed while waited");

  property p_readLanes;
    (memSelect && !dmaTakeover && !writeNotRead) |-> byteLanes == `LANES_NONE;
  endproperty
  a_readLanes: assert property (p_readLanes) else $error("read with byte lanes set");

  property p_dmaIndex;
    dmaTakeover |-> (wordIndex == dmaIndex) && !followOn;
  endproperty
  a_dmaIndex: assert property (p_dmaIndex) else $error("DMA index not passed through");

  property p_dmaSelect;
    (dmaTakeover && (dmaSelect || portQuiet)) |-> (memSelect == dmaSelect);
  endproperty
  a_dmaSelect: assert property (p_dmaSelect) else $error("DMA select not followed");

  property p_noSeqWrite;
    (INSTR_SIDE && memSelect && !dmaTakeover && writeNotRead) |-> !followOn;
  endproperty
  a_noSeqWrite: assert property (p_noSeqWrite) else $error("sequential instruction write");

  property p_dataBackToBack;
    (!INSTR_SIDE && memSelect && !dmaTakeover && followOn && !$past(stateReg.stallPrev))
      |-> $past(memSelect) && !$past(dmaTakeover);
  endproperty
  a_dataBackToBack: assert property (p_dataBackToBack) else $error("data seq not b2b");

  property p_reissueNseq;
    (dmaTakeover && !portQuiet) ##1 (!dmaTakeover && memSelect) |-> !followOn;
  endproperty
  a_reissueNseq: assert property (p_reissueNseq) else $error("seq after DMA");

  property p_readReturn;
    (memSelect && !dmaTakeover && !memStall && !writeNotRead) |-> ##2 respValid;
  endproperty
  a_readReturn: assert property (p_readReturn) else $error("zero wait read not returned");

  c_waitedWrite: cover property (memSelect && writeNotRead && memStall ##1 followOn);
  c_dmaStall: cover property (dmaTakeover && !portQuiet ##1 memSelect);
  c_seqBurst: cover property (memSelect && !memStall ##1 memSelect && followOn);
endmodule

// Data and instruction ports side by side, differing only in their sequencing.
module tightly_coupled_sram_port
  import tcm_port_pkg::*;
#(
  parameter int FIFO_DEPTH = `REQ_FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Shared endianness setting.
  input wire logic bigEndian,
  // Data side processor stream.
  input wire logic dataReqValid,
  output logic dataReqReady,
  input wire req_t dataReq,
  output logic dataRespValid,
  output logic [`DATA_W-1:0] dataRespWord,
  // Data side memory pins.
  output logic data_mem_select,
  input wire logic data_mem_stall,
  output logic data_port_quiet,
  output logic data_follow_on_flag,
  output logic [`WORD_INDEX_W-1:0] data_word_index,
  output logic [`LANE_W-1:0] data_byte_lanes,
  output logic data_write_not_read,
  input wire logic [`DATA_W-1:0] data_read_word,
  output logic [`DATA_W-1:0] data_write_word,
  input wire logic data_dma_takeover,
  input wire logic data_dma_select,
  input wire logic [`WORD_INDEX_W-1:0] data_dma_index,
  // Instruction side processor stream.
  input wire logic instrReqValid,
  output logic instrReqReady,
  input wire req_t instrReq,
  output logic instrRespValid,
  output logic [`DATA_W-1:0] instrRespWord,
  // Instruction side memory pins.
  output logic instr_mem_select,
  input wire logic instr_mem_stall,
  output logic instr_port_quiet,
  output logic instr_follow_on_flag,
  output logic [`WORD_INDEX_W-1:0] instr_word_index,
  output logic [`LANE_W-1:0] instr_byte_lanes,
  output logic instr_write_not_read,
  input wire logic [`DATA_W-1:0] instr_read_word,
  output logic [`DATA_W-1:0] instr_write_word,
  input wire logic instr_dma_takeover,
  input wire logic instr_dma_select,
  input wire logic [`WORD_INDEX_W-1:0] instr_dma_index
);
  // Data side port.
  tcm_port_side #(.INSTR_SIDE(1'b0), .FIFO_DEPTH(FIFO_DEPTH)) dataSide (
    .ref_clk(ref_clk), .sys_rst(sys_rst),
    .reqValid(dataReqValid), .reqReady(dataReqReady), .reqData(dataReq),
    .bigEndian(bigEndian), .respValid(dataRespValid), .respData(dataRespWord),
    .memSelect(data_mem_select), .memStall(data_mem_stall), .portQuiet(data_port_quiet),
    .followOn(data_follow_on_flag), .wordIndex(data_word_index),
    .byteLanes(data_byte_lanes), .writeNotRead(data_write_not_read),
    .readWord(data_read_word), .writeWord(data_write_word),
    .dmaTakeover(data_dma_takeover), .dmaSelect(data_dma_select), .dmaIndex(data_dma_index)
  );

  // Instruction side port, same logic with its own sequencing.
  tcm_port_side #(.INSTR_SIDE(1'b1), .FIFO_DEPTH(FIFO_DEPTH)) instrSide (
    .ref_clk(ref_clk), .sys_rst(sys_rst),
    .reqValid(instrReqValid), .reqReady(instrReqReady), .reqData(instrReq),
    .bigEndian(bigEndian), .respValid(instrRespValid), .respData(instrRespWord),
    .memSelect(instr_mem_select), .memStall(instr_mem_stall), .portQuiet(instr_port_quiet),
    .followOn(instr_follow_on_flag), .wordIndex(instr_word_index),
    .byteLanes(instr_byte_lanes), .writeNotRead(instr_write_not_read),
    .readWord(instr_read_word), .writeWord(instr_write_word),
    .dmaTakeover(instr_dma_takeover), .dmaSelect(instr_dma_select),
    .dmaIndex(instr_dma_index)
  );
endmodule

//--- verification/sram_partner.sv
`timescale 1ns/10ps
// Synchronous memory behind one port side, wait states set by the bench.
module sram_partner (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Memory pins of the port.
  input wire logic memSelect,
  output logic memStall,
  input wire logic [17:0] wordIndex,
  input wire logic [3:0] byteLanes,
  input wire logic writeNotRead,
  input wire logic [31:0] writeWord,
  output logic [31:0] readWord,
  // Bench controls: waited cycles per access, and stall level while idle.
  input wire logic [3:0] waitCycles,
  input wire logic idleStall
);
  logic [31:0] mem [256]; // Storage, indexed by the low index bits.
  logic [3:0] waitLeft_reg = 4'h0; // Waited cycles still to run.
  logic [17:0] index_reg; // Index captured in the request cycle.
  logic write_reg; // Direction captured in the request cycle.
  logic [3:0] lanes_reg; // Lanes captured in the request cycle.
  logic [31:0] rd_reg = 32'h0; // Last word read.
  logic fresh_reg = 1'b0; // High in the data cycle of a read.
  logic doIt; // The access takes place at the coming edge.
  logic [17:0] aIdx; // Index of that access.
  logic aWr; // Direction of that access.
  logic [3:0] aLn; // Lanes of that access.

  initial for (int i = 0; i < 256; i++) mem[i] = {24'h5A5A00, 8'(i)};

  // Stall rises with a waited select and falls one cycle before the data cycle.
  always_comb begin
    if (waitLeft_reg != 4'h0) memStall = waitLeft_reg > 4'h1;
    else if (memSelect) memStall = waitCycles != 4'h0;
    else memStall = idleStall;
  end

  // The access happens at the edge before the data cycle.
  assign doIt = waitLeft_reg == 4'h1 || (waitLeft_reg == 4'h0 && memSelect && waitCycles == 4'h0);
  assign aIdx = waitLeft_reg != 4'h0 ? index_reg : wordIndex;
  assign aWr = waitLeft_reg != 4'h0 ? write_reg : writeNotRead;
  assign aLn = waitLeft_reg != 4'h0 ? lanes_reg : byteLanes;

  // Wait counting, request capture and the array access.
  always @(posedge ref_clk) begin
    fresh_reg <= 1'b0;
    if (sys_rst) waitLeft_reg <= 4'h0;
    else if (waitLeft_reg != 4'h0) waitLeft_reg <= waitLeft_reg - 4'h1;
    else if (memSelect) begin
      waitLeft_reg <= waitCycles;
      index_reg <= wordIndex;
      write_reg <= writeNotRead;
      lanes_reg <= byteLanes;
    end
    if (!sys_rst && doIt && !aWr) begin
      rd_reg <= mem[aIdx[7:0]];
      fresh_reg <= 1'b1;
    end
    if (!sys_rst && doIt && aWr)
      for (int b = 0; b < 4; b++) if (aLn[b]) mem[aIdx[7:0]][8*b +: 8] <= writeWord[8*b +: 8];
  end

  // Outside the data cycle the bus shows the inverse of the last word.
  assign readWord = fresh_reg ? rd_reg : ~rd_reg;
endmodule

//--- verification/test_tightly_coupled_sram_port.sv
`timescale 1ns/10ps
// Self-checking bench for both port sides against behavioural memories.
module test_tightly_coupled_sram_port import tcm_port_pkg::*;;
  logic ref_clk, sys_rst, bigEndian, dSpec, sawFull;
  logic dataReqValid, dataReqReady, dataRespValid, instrReqValid, instrReqReady, instrRespValid;
  req_t dataReq, instrReq;
  logic [31:0] dataRespWord, instrRespWord, data_read_word, instr_read_word;
  logic [31:0] data_write_word, instr_write_word, holdW;
  logic data_mem_select, data_mem_stall, data_port_quiet, data_follow_on_flag, data_write_not_read;
  logic instr_mem_select, instr_mem_stall, instr_port_quiet, instr_follow_on_flag;
  logic instr_write_not_read, data_dma_takeover, data_dma_select, instr_dma_takeover;
  logic instr_dma_select, hw;
  logic [17:0] data_word_index, instr_word_index, data_dma_index, instr_dma_index;
  logic [3:0] data_byte_lanes, instr_byte_lanes, dWaits;
  int mismatches, num_checks, badWait, cyc;
  // Issue log of the data side, read answers of both sides.
  logic [17:0] dIdx[$];
  logic [3:0] dLn[$];
  logic dSeq[$], iSeq[$];
  int dCyc[$];
  logic [31:0] dRsp[$], iRsp[$];

  tightly_coupled_sram_port #(.FIFO_DEPTH(16)) u_dut (.ref_clk, .sys_rst, .bigEndian,
    .dataReqValid, .dataReqReady, .dataReq, .dataRespValid, .dataRespWord, .data_mem_select,
    .data_mem_stall, .data_port_quiet, .data_follow_on_flag, .data_word_index, .data_byte_lanes,
    .data_write_not_read, .data_read_word, .data_write_word, .data_dma_takeover,
    .data_dma_select, .data_dma_index, .instrReqValid, .instrReqReady, .instrReq,
    .instrRespValid, .instrRespWord, .instr_mem_select, .instr_mem_stall, .instr_port_quiet,
    .instr_follow_on_flag, .instr_word_index, .instr_byte_lanes, .instr_write_not_read,
    .instr_read_word, .instr_write_word, .instr_dma_takeover, .instr_dma_select,
    .instr_dma_index);
  sram_partner u_dmem (.ref_clk, .sys_rst, .memSelect(data_mem_select),
    .memStall(data_mem_stall), .wordIndex(data_word_index), .byteLanes(data_byte_lanes),
    .writeNotRead(data_write_not_read), .writeWord(data_write_word),
    .readWord(data_read_word), .waitCycles(dWaits), .idleStall(dSpec));
  sram_partner u_imem (.ref_clk, .sys_rst, .memSelect(instr_mem_select),
    .memStall(instr_mem_stall), .wordIndex(instr_word_index), .byteLanes(instr_byte_lanes),
    .writeNotRead(instr_write_not_read), .writeWord(instr_write_word),
    .readWord(instr_read_word), .waitCycles(4'h0), .idleStall(1'b0));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // Logs settled outputs; waited cycles must hold the flag high and the data.
  always @(posedge ref_clk) begin
    #2;
    cyc++;
    if (dataReqValid === 1'b1 && dataReqReady !== 1'b1) sawFull = 1'b1;
    if (data_mem_select === 1'b1) begin
      dIdx.push_back(data_word_index);
      dLn.push_back(data_byte_lanes);
      dSeq.push_back(data_follow_on_flag);
      dCyc.push_back(cyc);
      holdW = data_write_word;
      hw = data_write_not_read;
    end else if (u_dmem.waitLeft_reg != 4'h0) begin
      if (data_follow_on_flag !== 1'b1 || (hw && data_write_word !== holdW)) badWait++;
    end
    if (instr_mem_select === 1'b1) iSeq.push_back(instr_follow_on_flag);
    if (dataRespValid === 1'b1) dRsp.push_back(dataRespWord);
    if (instrRespValid === 1'b1) iRsp.push_back(instrRespWord);
  end

  // Counts one comparison and reports it when it fails.
  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic end_of_test();
    if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Offers one request and returns just after the edge that takes it; valid stays up.
  task automatic push(input bit ins, input logic w, input logic [19:0] a, input size_t s,
                      input logic [31:0] d);
    if (ins) begin
      instrReq = '{w, a, s, d};
      instrReqValid = 1'b1;
    end else begin
      dataReq = '{w, a, s, d};
      dataReqValid = 1'b1;
    end
    while ((ins ? instrReqReady : dataReqReady) !== 1'b1) begin
      @(posedge ref_clk);
      #1;
    end
    @(posedge ref_clk);
    #1;
  endtask

  // Withdraws both request streams.
  task automatic stop();
    dataReqValid = 1'b0;
    instrReqValid = 1'b0;
  endtask

  // Empties the logs.
  task automatic clr();
    dIdx.delete(); dLn.delete(); dSeq.delete(); dCyc.delete();
    dRsp.delete(); iSeq.delete(); iRsp.delete();
  endtask

  // Waits, bounded, until both sides have been quiet long enough.
  task automatic drain();
    int q;
    q = 0;
    for (int i = 0; i < 600 && q < 14; i++) begin
      @(posedge ref_clk);
      #2;
      q = (data_port_quiet === 1'b1 && instr_port_quiet === 1'b1) ? q + 1 : 0;
    end
    check(q >= 14, "ports never quiet");
    @(posedge ref_clk);
    #1;
  endtask

  // Expected write lanes; big endian mirrors the byte offset.
  function automatic logic [3:0] lanes(input logic be, input size_t s, input logic [1:0] o);
    logic [1:0] e;
    e = be ? ~o : o;
    if (s == SIZE_WORD) return 4'hF;
    if (s == SIZE_HALF) return e[1] ? 4'hC : 4'h3;
    return 4'h1 << e;
  endfunction

  // Back-to-back writes then reads with zero waits.
  task automatic t_basic();
    clr();
    push(0, 1'b1, 20'h00040, SIZE_WORD, 32'hA5A50001);
    push(0, 1'b1, 20'h00044, SIZE_WORD, 32'hA5A50002);
    push(0, 1'b0, 20'h00040, SIZE_WORD, 32'h0);
    push(0, 1'b0, 20'h00044, SIZE_WORD, 32'h0);
    stop();
    drain();
    check(dIdx.size() == 4 && dCyc[3] - dCyc[0] == 3, "issues not back to back");
    check(dIdx[0] === 18'h00010 && dIdx[3] === 18'h00011, "word index");
    check(dLn[0] === 4'hF && dLn[2] === 4'h0 && dLn[3] === 4'h0, "word or read lanes");
    check(dSeq[1] === 1'b1 && dSeq[2] === 1'b0 && dSeq[3] === 1'b1, "follow-on flag");
    check(dRsp.size() == 2 && dRsp[0] === 32'hA5A50001 && dRsp[1] === 32'hA5A50002,
          "read data");
  endtask

  // Every size and aligned offset in both endian settings.
  task automatic t_lanes();
    logic [3:0] ex[$];
    size_t s;
    logic [1:0] o;
    for (int be = 0; be < 2; be++) begin
      clr();
      ex.delete();
      bigEndian = be[0];
      for (int k = 0; k < 7; k++) begin
        s = k < 4 ? SIZE_BYTE : (k < 6 ? SIZE_HALF : SIZE_WORD);
        o = k < 4 ? 2'(k) : (k == 5 ? 2'h2 : 2'h0);
        ex.push_back(lanes(be[0], s, o));
        push(0, 1'b1, {18'h00050, o}, s, 32'h0);
      end
      stop();
      drain();
      for (int k = 0; k < 7; k++) check(dLn.size() == 7 && dLn[k] === ex[k], "lanes");
    end
    bigEndian = 1'b0;
  endtask

  // Three waits per access; a waited access breaks the data side sequence.
  task automatic t_wait();
    clr();
    badWait = 0;
    dWaits = 4'h3;
    push(0, 1'b1, 20'h00080, SIZE_WORD, 32'h12345678);
    push(0, 1'b0, 20'h00080, SIZE_WORD, 32'h0);
    push(0, 1'b0, 20'h00084, SIZE_WORD, 32'h0);
    stop();
    drain();
    dWaits = 4'h0;
    check(badWait == 0, "flag or write word moved while waited");
    check(dRsp.size() == 2 && dRsp[0] === 32'h12345678 && dRsp[1] === 32'h5A5A0021,
          "waited read data");
    check(dSeq.size() == 3 && dSeq[2] === 1'b0 && dCyc[1] - dCyc[0] == 4, "waited spacing");
  endtask

  // Stall held high while idle must not disturb a zero-wait read.
  task automatic t_spec();
    clr();
    dSpec = 1'b1;
    push(0, 1'b0, 20'h00088, SIZE_WORD, 32'h0);
    stop();
    drain();
    dSpec = 1'b0;
    check(dIdx.size() == 1 && dRsp.size() == 1 && dRsp[0] === 32'h5A5A0022,
          "idle stall not ignored");
  endtask

  // Takeover while idle, then while a request waits; the stalled request reissues.
  task automatic t_dma();
    push(0, 1'b0, 20'h0008C, SIZE_WORD, 32'h0);
    stop();
    drain();
    data_dma_takeover = 1'b1;
    data_dma_select = 1'b1;
    data_dma_index = 18'h3FF07;
    #1;
    check(data_mem_select === 1'b1 && data_word_index === 18'h3FF07 &&
          data_follow_on_flag === 1'b0, "takeover steering");
    @(posedge ref_clk);
    #1;
    data_dma_select = 1'b0;
    #1;
    check(data_mem_select === 1'b0 && data_port_quiet === 1'b1, "takeover deselect");
    @(posedge ref_clk);
    #1;
    data_dma_select = 1'b1;
    push(0, 1'b0, 20'h00090, SIZE_WORD, 32'h0);
    stop();
    repeat (3) @(posedge ref_clk);
    #2;
    check(data_port_quiet === 1'b0 && dataReqReady === 1'b1, "request not held");
    @(posedge ref_clk);
    #1;
    clr();
    data_dma_takeover = 1'b0;
    data_dma_select = 1'b0;
    drain();
    check(dIdx.size() == 1 && dIdx[0] === 18'h00024 && dSeq[0] === 1'b0 &&
          dRsp.size() == 1 && dRsp[0] === 32'h5A5A0024, "reissue after takeover");
  endtask

  // Instruction side: sequential after idle cycles, never a sequential write, DMA steering.
  task automatic t_instr();
    clr();
    push(1, 1'b1, 20'h00100, SIZE_WORD, 32'hCAFE0001);
    push(1, 1'b0, 20'h00100, SIZE_WORD, 32'h0);
    stop();
    repeat (5) @(posedge ref_clk);
    #1;
    push(1, 1'b0, 20'h00104, SIZE_WORD, 32'h0);
    stop();
    repeat (5) @(posedge ref_clk);
    #1;
    push(1, 1'b1, 20'h00108, SIZE_WORD, 32'h0);
    stop();
    drain();
    check(iSeq.size() == 4 && iSeq[2] === 1'b1 && iSeq[3] === 1'b0, "instr follow-on");
    check(iRsp.size() == 2 && iRsp[0] === 32'hCAFE0001 && iRsp[1] === 32'h5A5A0041,
          "instr read data");
    instr_dma_takeover = 1'b1;
    instr_dma_select = 1'b1;
    instr_dma_index = 18'h00155;
    #1;
    check(instr_mem_select === 1'b1 && instr_word_index === 18'h00155, "instr takeover");
    @(posedge ref_clk);
    #1;
    instr_dma_takeover = 1'b0;
    instr_dma_select = 1'b0;
  endtask

  // Slow memory fills the FIFO until it refuses, then everything drains in order.
  task automatic t_fifo();
    clr();
    sawFull = 1'b0;
    dWaits = 4'h8;
    for (int i = 0; i < 20; i++) push(0, 1'b0, 20'h00200 + 20'(i * 4), SIZE_WORD, 32'h0);
    stop();
    drain();
    dWaits = 4'h0;
    check(sawFull === 1'b1 && dataReqReady === 1'b1 && dRsp.size() == 20, "fill and drain");
    for (int i = 0; i < 20; i++) check(dRsp[i] === 32'h5A5A0080 + 32'(i), "fifo order");
  endtask

  initial begin
    sys_rst = 1'b1;
    bigEndian = 1'b0;
    dSpec = 1'b0;
    dWaits = 4'h0;
    dataReqValid = 1'b0;
    instrReqValid = 1'b0;
    dataReq = '0;
    instrReq = '0;
    data_dma_takeover = 1'b0;
    data_dma_select = 1'b0;
    data_dma_index = 18'h0;
    instr_dma_takeover = 1'b0;
    instr_dma_select = 1'b0;
    instr_dma_index = 18'h0;
    hw = 1'b0;
    repeat (16) @(posedge ref_clk);
    #1;
    check(data_mem_select === 1'b0 && data_port_quiet === 1'b1 &&
          instr_mem_select === 1'b0 && instr_port_quiet === 1'b1, "reset outputs");
    sys_rst = 1'b0;
    t_basic();
    t_lanes();
    t_wait();
    t_spec();
    t_dma();
    t_instr();
    t_fifo();
    end_of_test();
  end

  // Ends a hung run; all tests need well under a thousand cycles.
  initial begin
    #200000;
    mismatches++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    end_of_test();
  end
endmodule
